// *** rtl/adc_seq12_sample_config.sv ***
// sample configuration bank and step engine for sequencers 1 and 2
`timescale 1ns/1ps
module adc_seq12_sample_config #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DATA_W = 10
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o,
  output logic                   conv_req_o,
  output logic      [1:0]        conv_input_o,
  output logic                   conv_temp_o,
  output logic                   conv_diff_o,
  output logic                   conv_seq_o,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  output logic                   res_valid_o,
  output logic      [DATA_W-1:0] res_data_o,
  output logic                   res_seq_o,
  output logic      [1:0]        res_index_o,
  output logic                   res_last_o
);
  import adc_seq_cfg_pkg::*;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must lie in 12..32");
  end
  if (DATA_W < 1 || DATA_W > 32) begin : g_chk_data
    $error("DATA_W must lie in 1..32");
  end

  logic [15:0]        insel_q [NUM_SEQ];
  logic [15:0]        ctl_q   [NUM_SEQ];
  logic [1:0]         pend_q;
  logic [1:0]         irq_stat_q;
  logic [1:0]         irq_mask_q;
  seq_state_t         state_q;
  logic               seq_q;
  logic [1:0]         idx_q;
  logic               cur_last_q;
  logic               cur_irq_q;
  logic [1:0]         conv_input_q;
  logic               conv_temp_q;
  logic               conv_diff_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic               res_valid_q;
  logic [DATA_W-1:0]  res_data_q;
  logic               res_seq_q;
  logic [1:0]         res_index_q;
  logic               res_last_q;

  logic               setup;
  logic               addr_hi_ok;
  logic               wr_en;
  logic [11:0]        addr;
  logic [31:0]        rd_data;
  logic               rd_err;
  logic               grant;
  logic               grant_seq;
  logic               step_done;
  logic               seq_end;
  logic               load;
  logic               load_seq;
  logic [1:0]         load_idx;
  logic [3:0]         load_base;
  logic [1:0]         load_insel;
  logic [3:0]         load_ctl;
  logic [1:0]         busy;

  assign addr      = paddr_i[11:0];
  // bits above the 12-bit map must be zero, or the access is unmapped
  assign addr_hi_ok = (ADDR_W'(addr) == paddr_i);
  assign setup     = psel_i && !penable_i;
  assign wr_en     = psel_i && penable_i && pwrite_i && addr_hi_ok;
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  // per-sequencer configuration registers
  for (genvar s = 0; s < NUM_SEQ; s++) begin : g_seq
    localparam logic [11:0] INSEL_OFS = (s == 0) ? OFS_SEQ1_INSEL
                                                 : OFS_SEQ2_INSEL;
    localparam logic [11:0] CTL_OFS   = (s == 0) ? OFS_SEQ1_CTL
                                                 : OFS_SEQ2_CTL;
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        insel_q[s] <= CFG_RESET;
      end else if (wr_en && addr == INSEL_OFS) begin
        insel_q[s] <= pwdata_i[15:0] & INSEL_MASK;
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        ctl_q[s] <= CFG_RESET;
      end else if (wr_en && addr == CTL_OFS) begin
        ctl_q[s] <= pwdata_i[15:0] & CTL_MASK;
      end
    end
  end

  // read decode; unmapped addresses answer zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (addr)
      OFS_START:      rd_data = 32'h0000_0000;
      OFS_BUSY:       rd_data = {30'h0000_0000, busy};
      OFS_IRQ_STAT:   rd_data = {30'h0000_0000, irq_stat_q};
      OFS_IRQ_MASK:   rd_data = {30'h0000_0000, irq_mask_q};
      OFS_SEQ1_INSEL: rd_data = {16'h0000, insel_q[0]};
      OFS_SEQ1_CTL:   rd_data = {16'h0000, ctl_q[0]};
      OFS_SEQ2_INSEL: rd_data = {16'h0000, insel_q[1]};
      OFS_SEQ2_CTL:   rd_data = {16'h0000, ctl_q[1]};
      default:        rd_err  = 1'b1;
    endcase
    if (!addr_hi_ok) begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b1;
    end
  end

  // answer captured in setup so it is stable through the access phase
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= rd_err;
    end
  end

  // start requests; a new start in the grant cycle stays pending
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pend_q <= 2'b00;
    end else begin
      pend_q <= (pend_q & ~({1'b0, grant && !grant_seq} |
                            {grant && grant_seq, 1'b0}))
              | ((wr_en && addr == OFS_START) ? pwdata_i[1:0] : 2'b00);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= 2'b00;
    end else if (wr_en && addr == OFS_IRQ_MASK) begin
      irq_mask_q <= pwdata_i[1:0];
    end
  end

  // sequencer 1 has priority when both wait
  assign grant     = (state_q == ST_IDLE) && (pend_q != 2'b00);
  assign grant_seq = !pend_q[0];
  assign step_done = (state_q == ST_CONV) && conv_done_i;
  assign seq_end   = cur_last_q || (idx_q == 2'(NUM_SAMPLES - 1));
  assign load      = grant || (step_done && !seq_end);
  assign load_seq  = grant ? grant_seq : seq_q;
  assign load_idx  = grant ? 2'b00 : 2'(idx_q + 2'b01);
  assign load_base = {load_idx, 2'b00};

  // field pick by sample slot
  assign load_insel = insel_q[load_seq][load_base +: INSEL_W];
  // nibble pick by slot
  assign load_ctl   = ctl_q[load_seq][load_base +: CTL_W];

  assign busy[0] = pend_q[0] || (state_q == ST_CONV && !seq_q);
  assign busy[1] = pend_q[1] || (state_q == ST_CONV && seq_q);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (grant) state_q <= ST_CONV;
        ST_CONV: if (step_done && seq_end) state_q <= ST_IDLE;
      endcase
    end
  end

  // slot settings are copied so edits mid-sequence do not glitch a step
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      seq_q <= 1'b0;
    end else if (load) begin
      seq_q <= load_seq;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      idx_q <= 2'b00;
    end else if (load) begin
      idx_q <= load_idx;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cur_last_q <= 1'b0;
    end else if (load) begin
      cur_last_q <= load_ctl[CTL_LAST_POS];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cur_irq_q <= 1'b0;
    end else if (load) begin
      cur_irq_q <= load_ctl[CTL_IRQEN_POS];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      conv_input_q <= 2'b00;
    end else if (load) begin
      conv_input_q <= load_insel;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      conv_temp_q <= 1'b0;
    end else if (load) begin
      conv_temp_q <= load_ctl[CTL_TEMP_POS];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      conv_diff_q <= 1'b0;
    end else if (load) begin
      conv_diff_q <= load_ctl[CTL_DIFF_POS];
    end
  end

  assign conv_req_o   = (state_q == ST_CONV);
  assign conv_seq_o   = seq_q;
  assign conv_input_o = conv_input_q;
  assign conv_temp_o  = conv_temp_q;
  assign conv_diff_o  = conv_diff_q;

  // results leave one per step, in slot order
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= step_done;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      res_data_q <= '0;
    end else if (step_done) begin
      res_data_q <= conv_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      res_seq_q <= 1'b0;
    end else if (step_done) begin
      res_seq_q <= seq_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      res_index_q <= 2'b00;
    end else if (step_done) begin
      res_index_q <= idx_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      res_last_q <= 1'b0;
    end else if (step_done) begin
      res_last_q <= seq_end;
    end
  end

  assign res_valid_o = res_valid_q;
  assign res_data_o  = res_data_q;
  assign res_seq_o   = res_seq_q;
  assign res_index_o = res_index_q;
  assign res_last_o  = res_last_q;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 2'b00;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_en && addr == OFS_IRQ_STAT) ? pwdata_i[1:0]
                                                       : 2'b00))
                  | {step_done && cur_irq_q && seq_q,
                     step_done && cur_irq_q && !seq_q};
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule // adc_seq12_sample_config

// *** rtl/adc_seq_cfg_pkg.sv ***
// constants, register map and types of the sequencer 1/2 sample configuration bank
// Functional notes
// - each input-select register holds four 2-bit sample input selections in 16 bits.
// - first sample input comes from input-select bits 1:0.
// - second sample input comes from input-select bits 5:4.
// - third sample input comes from input-select bits 9:8.
// - fourth sample input comes from input-select bits 13:12.
// - input-select bits 31:14, 11:10, 7:6, 3:2 read zero, writes ignored.
// - sample-control bits 31:16 read zero, writes ignored.
// - fourth sample control: temp bit 15, irq 14, last 13, diff 12.
// - third sample control: temp bit 11, irq 10, last 9, diff 8.
// - second sample control: temp bit 7, irq 6, last 5, diff 4.
// - first sample control: temp bit 3, irq 2, last 1, diff 0.
// - results leave in sample order, first sample first.
package adc_seq_cfg_pkg;

  localparam int unsigned NUM_SEQ     = 2;
  localparam int unsigned NUM_SAMPLES = 4;
  localparam int unsigned FIELD_STEP  = 4;
  localparam int unsigned INSEL_W     = 2;
  localparam int unsigned CTL_W       = 4;

  // byte offsets
  localparam logic [11:0] OFS_START     = 12'h000;
  localparam logic [11:0] OFS_BUSY      = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h00C;
  localparam logic [11:0] OFS_SEQ1_INSEL = 12'h060;
  localparam logic [11:0] OFS_SEQ1_CTL   = 12'h064;
  localparam logic [11:0] OFS_SEQ2_INSEL = 12'h080;
  localparam logic [11:0] OFS_SEQ2_CTL   = 12'h084;

  // writable bits; everything else reads zero
  localparam logic [15:0] INSEL_MASK = 16'h3333;
  localparam logic [15:0] CTL_MASK   = 16'hFFFF;
  localparam logic [15:0] CFG_RESET  = 16'h0000;

  // bit positions inside one control nibble
  localparam int unsigned CTL_DIFF_POS  = 0;
  localparam int unsigned CTL_LAST_POS  = 1;
  localparam int unsigned CTL_IRQEN_POS = 2;
  localparam int unsigned CTL_TEMP_POS  = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

endpackage

// *** tb/adc_seq12_sample_config_tb.sv ***
// self-checking bench for the sequencer sample configuration bank
`timescale 1ns/1ps
module adc_seq12_sample_config_tb;
  import adc_seq_cfg_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        conv_done_i = 1'b0;
  logic [9:0]  conv_data_i = 10'h000;
  logic [31:0] prdata_o, rd, ins, ctl, d;
  logic [9:0]  res_data_o;
  logic [1:0]  conv_input_o, res_index_o;
  logic        pready_o, pslverr_o, irq_o, conv_req_o, conv_temp_o;
  logic        conv_diff_o, conv_seq_o, res_valid_o, res_seq_o;
  logic        res_last_o, err, irq;
  logic [11:0] ofs [4] = '{OFS_SEQ1_INSEL, OFS_SEQ1_CTL,
                           OFS_SEQ2_INSEL, OFS_SEQ2_CTL};
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n, lst;

  adc_seq12_sample_config adc_seq12_sample_config_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .conv_req_o(conv_req_o),
    .conv_input_o(conv_input_o), .conv_temp_o(conv_temp_o),
    .conv_diff_o(conv_diff_o), .conv_seq_o(conv_seq_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .res_valid_o(res_valid_o), .res_data_o(res_data_o),
    .res_seq_o(res_seq_o), .res_index_o(res_index_o),
    .res_last_o(res_last_o)
  );

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task summarize();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // config readback keeps only the writable fields
  function logic [31:0] keep(input logic [11:0] a, input logic [31:0] v);
    return v & {16'h0, a[2] ? CTL_MASK : INSEL_MASK};
  endfunction

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'h4A47));
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, 32'h0);
    end
    for (int r = 0; r < 6; r++) foreach (ofs[i]) begin
      ins = (r == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1'b1, ofs[i], ins);
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, keep(ofs[i], ins));
      chk({31'h0, err}, 32'h0);
    end
    apb(1'b0, 12'h070, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int s = 0; s < 2; s++) for (int k = 0; k < 5; k++) begin
      ins = $urandom & 32'h3333;
      ctl = $urandom & 32'hDDDD;
      lst = (k < 4) ? k : $urandom % 4;
      ctl[4*lst+1] = 1'b1;
      n = lst + 1;
      irq = 1'b0;
      apb(1'b1, ofs[2*s], ins);
      apb(1'b1, ofs[2*s+1], ctl);
      apb(1'b1, OFS_IRQ_MASK, {31'h0, k[0]} << s);
      apb(1'b1, OFS_START, 32'h1 << s);
      apb(1'b0, OFS_BUSY, 32'h0);
      chk(rd, 32'h1 << s);
      for (int j = 0; j < n; j++) begin
        for (int t = 0; t < 20 && conv_req_o !== 1'b1; t++)
          @(negedge ref_clk_i);
        chk({conv_seq_o, conv_input_o, conv_temp_o, conv_diff_o},
            {s[0], ins[4*j+:2], ctl[4*j+3], ctl[4*j]});
        irq |= ctl[4*j+2];
        repeat ($urandom % 3) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        d = $urandom;
        conv_done_i <= 1'b1;
        conv_data_i <= d[9:0];
        @(posedge ref_clk_i);
        conv_done_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({res_valid_o, res_seq_o, res_index_o, res_last_o, res_data_o},
            {1'b1, s[0], j[1:0], j == n - 1, d[9:0]});
      end
      // stray done pulse while idle must be ignored
      @(posedge ref_clk_i);
      conv_done_i <= 1'b1;
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
      @(negedge ref_clk_i);
      chk(res_valid_o, 1'b0);
      repeat (3) @(posedge ref_clk_i);
      chk(conv_req_o, 1'b0);
      chk(irq_o, irq & k[0]);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, {31'h0, irq} << s);
      apb(1'b1, OFS_IRQ_STAT, 32'h1 << s);
      @(posedge ref_clk_i);
      chk(irq_o, 1'b0);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
    end
    summarize();
  end
endmodule // adc_seq12_sample_config_tb

// *** tb/adc_seq_cfg_props.sv ***
// assertion checker for the sequencer sample configuration bank
`timescale 1ns/1ps
module adc_seq_cfg_props
  import adc_seq_cfg_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DATA_W = 10
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              conv_req_o,
  input wire logic              conv_done_i,
  input wire logic [1:0]        conv_input_o,
  input wire logic              conv_diff_o,
  input wire logic              res_valid_o,
  input wire logic [1:0]        res_index_o,
  input wire logic              res_last_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence acc_s(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b);
    psel_i && penable_i && (paddr_i == a || paddr_i == b);
  endsequence
  sequence step_s;
    conv_req_o && conv_done_i;
  endsequence
  res_after_done_a: assert property (step_s |=> res_valid_o)
    else $error("no result after a finished step");
  res_cause_a: assert property (res_valid_o |-> $past(conv_req_o && conv_done_i))
    else $error("result without a finished step");
  done_ignored_a: assert property (conv_done_i && !conv_req_o |=> !res_valid_o)
    else $error("result from an idle done pulse");
  more_steps_a: assert property (res_valid_o && !res_last_o |-> conv_req_o)
    else $error("sequence stopped before its last step");
  last_stops_a: assert property (res_valid_o && res_last_o |-> !conv_req_o)
    else $error("sequence ran past its last step");
  slot_end_a: assert property (res_valid_o && res_index_o == 2'h3 |-> res_last_o)
    else $error("fourth step not marked last");
  step_hold_a: assert property (conv_req_o && !conv_done_i |=> $stable({conv_input_o, conv_diff_o}))
    else $error("step settings changed mid step");
  rdata_hold_a: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data changed outside setup");
  insel_zero_a: assert property (acc_s(OFS_SEQ1_INSEL, OFS_SEQ2_INSEL) |-> (prdata_o & 32'hFFFFCCCC) == 32'h0)
    else $error("input select reserved bits set");
  ctl_zero_a: assert property (acc_s(OFS_SEQ1_CTL, OFS_SEQ2_CTL) |-> prdata_o[31:16] == 16'h0)
    else $error("control upper bits set");
endmodule // adc_seq_cfg_props

bind adc_seq12_sample_config adc_seq_cfg_props #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)
) adc_seq_cfg_props_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .conv_req_o(conv_req_o), .conv_done_i(conv_done_i),
  .conv_input_o(conv_input_o), .conv_diff_o(conv_diff_o),
  .res_valid_o(res_valid_o), .res_index_o(res_index_o),
  .res_last_o(res_last_o)
);
